// ### spg_cpu_model.sv
// Purpose: Behavioural CPU core that issues sleep and raises interrupts.
// Assumes: Shares the controller clock.
// Notes:   A pending interrupt is kept until the CPU hold ends.
`timescale 1ns/1ps
module spg_cpu_model
  import spg_pkg::*;
(
  // Clock, reset and bench commands
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       go,
  input  wire logic       arm,
  input  wire logic [1:0] mode,
  input  wire logic       irq,
  // Controller status
  input  wire logic       cpu_hold,
  // Controller inputs
  output logic            sleep_instr,
  output logic            sleep_arm_bit,
  output logic [1:0]      sleep_mode_select,
  output logic            irq_enabled_pending
);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sleep_instr         <= 1'b0;
      sleep_arm_bit       <= 1'b0;
      sleep_mode_select   <= 2'h0;
      irq_enabled_pending <= 1'b0;
    end else begin
      sleep_instr         <= go && !cpu_hold;
      sleep_arm_bit       <= arm;
      sleep_mode_select   <= mode;
      irq_enabled_pending <= irq || (irq_enabled_pending && cpu_hold);
    end
  end
endmodule : spg_cpu_model

// ### spg_periph_gate.sv
// Purpose: Per-peripheral clock gate with register access block.
// Assumes: Gate enable is registered; state is frozen by stopping the clock.
// Notes:   No state is reset by gating, so the peripheral resumes where it stopped.
`timescale 1ns/1ps
module spg_periph_gate
  import spg_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Control
  input  wire logic pr_bit,
  input  wire logic domain_on,
  // Outputs
  output logic      clk_en,
  output logic      access_en
);

  logic clk_en_nxt;

  always_comb begin
    clk_en_nxt = domain_on & ~pr_bit;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      clk_en    <= 1'b1;
      access_en <= 1'b1;
    end else begin
      clk_en    <= clk_en_nxt;
      access_en <= ~pr_bit;
    end
  end

endmodule : spg_periph_gate

// ### spg_pkg.sv
// Purpose: Shared constants and types for the sleep and power-gating controller.
// Assumes: One 40 MHz system clock; all control bits arrive as plain ports.
// Notes:   Mode codes follow the two-bit sleep mode select field.
package spg_pkg;

  // ----------------------------------------------------------------------
  // Mode select codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] SPG_SM_IDLE    = 2'h0;
  localparam logic [1:0] SPG_SM_ADCNR   = 2'h1;
  localparam logic [1:0] SPG_SM_PWRDOWN = 2'h2;
  localparam logic [1:0] SPG_SM_STANDBY = 2'h3;

  // ----------------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------------
  localparam int unsigned SPG_CLK_MHZ        = 40;
  localparam int unsigned SPG_WAKE_HOLD_CYC  = 4;
  localparam int unsigned SPG_STANDBY_WAKE_CYC = 6;
  localparam int unsigned SPG_OSC_START_NS   = 1000;
  localparam int unsigned SPG_OSC_START_CYC  =
    (SPG_OSC_START_NS * SPG_CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  SPG_PRR_RESET      = 8'h00;

  // ----------------------------------------------------------------------
  // Peripheral bit positions in the power reduction register
  // ----------------------------------------------------------------------
  localparam int unsigned SPG_PR_ADC    = 0;
  localparam int unsigned SPG_PR_TWI    = 7;
  localparam int unsigned SPG_NUM_PERIPH = 8;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wdt_irq;
    logic ext_level_irq;
    logic pin_change_irq;
    logic mem_ready_irq;
    logic adc_done_irq;
    logic start_frame_irq;
    logic twi_addr_match_irq;
    logic other_irq;
  } spg_wake_t;

  typedef struct packed {
    logic osc_en;
    logic clk_cpu_en;
    logic clk_flash_en;
    logic clk_io_en;
    logic clk_adc_en;
  } spg_gate_t;

endpackage : spg_pkg

// ### spg_sleep_ctrl.sv
// Purpose: Sleep mode sequencer and clock domain gating for a small controller.
// Assumes: Wake and reset-request inputs come from pins or asynchronous logic.
// Notes:   Memory contents are never touched; only clock, access, CPU and analog controls are steered.
`timescale 1ns/1ps

// What this block does
// - Sleep entered only if arm bit is one when sleep instruction runs.
// - Mode select field picks which sleep mode the instruction enters.
// - Select codes: 00 idle, 01 ADC noise, 10 power-down, 11 standby.
// - After interrupt wake, CPU held four extra cycles, then resumes.
// - Sleep and wake leave register file and SRAM unchanged.
// - Reset during sleep wakes and restarts at the reset vector.
// - Idle stops only CPU and flash clocks.
// - Idle wakes on any enabled interrupt, external or internal.
// - Enabled ADC starts a conversion on entering idle or ADC noise mode.
// - ADC noise mode stops I/O, CPU and flash clocks only.
// - ADC noise mode wakes on resets, level, pin, ADC, memory, frame, address.
// - Power-down stops oscillator and every derived clock.
// - Power-down and standby wake only on resets, level, pin, frame, address.
// - Standby is power-down with oscillator kept; wake within six cycles.
// - Power reduction bit stops clock, freezes state, blocks register access.
// - Clearing power reduction bit restarts clock from the frozen state.
// - Per-peripheral gating applies in active and idle, and to the ADC in ADC noise; power-down and standby stop all.
// - Enabled ADC stays enabled; after off and on, next conversion extended.
// - Comparator auto-off in standby and power-down unless on internal reference.
// - Fuse-enabled brown-out detector stays on in sleep, optionally sampled.
// - Internal reference on whenever detector, comparator or ADC need it.
module spg_sleep_ctrl
  import spg_pkg::*;
#(
  parameter int unsigned OSC_START_CYC = SPG_OSC_START_CYC
)
(
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset,
  // CPU side
  input  wire logic                      sleep_instr,
  input  wire logic                      sleep_arm_bit,
  input  wire logic [1:0]                sleep_mode_select,
  input  wire logic                      irq_enabled_pending,
  // Wake sources, asynchronous
  input  wire spg_wake_t                 wake_src,
  input  wire logic                      reset_req,
  // Peripheral configuration
  input  wire logic [SPG_NUM_PERIPH-1:0] power_reduction_reg,
  input  wire logic                      adc_enable,
  input  wire logic                      comp_enable,
  input  wire logic                      comp_uses_ref,
  input  wire logic                      brownout_sleep_fuse,
  input  wire logic                      brownout_sampled_sel,
  // Clock domain controls
  output spg_gate_t                      gate,
  output logic      [SPG_NUM_PERIPH-1:0] periph_clk_en,
  output logic      [SPG_NUM_PERIPH-1:0] periph_access_en,
  // CPU status
  output logic                           cpu_hold,
  output logic                           cpu_restart,
  output logic                           asleep,
  // Analog controls
  output logic                           adc_auto_start,
  output logic                           adc_extended_conv,
  output logic                           comp_active,
  output logic                           brownout_active,
  output logic                           brownout_sampled,
  output logic                           vref_enable
);

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  // The start-up count must be nonzero and must fit the 16-bit wake counter.
  if (OSC_START_CYC == 32'h00000000 || OSC_START_CYC > 32'h0000ffff) begin : g_bad_osc_start
    $error("OSC_START_CYC must lie between 1 and 65535");
  end

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [8:0] sync1_r;
  logic [8:0] sync2_r;
  logic [8:0] sync_nxt;

  always_comb begin
    sync_nxt = {reset_req, wake_src};
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
    end else begin
      sync1_r <= sync_nxt;
      sync2_r <= sync1_r;
    end
  end

  spg_wake_t w;
  logic      rst_s;
  assign w     = spg_wake_t'(sync2_r[7:0]);
  assign rst_s = sync2_r[8];

  // ----------------------------------------------------------------------
  // Sleep state machine
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_START = 4'b0100,
    ST_HOLD  = 4'b1000
  } spg_state_t;

  spg_state_t  state_r, state_nxt;
  logic [1:0]  mode_r, mode_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        restart_r, restart_nxt;
  logic        wake_any;

  // Wake qualification per mode; the deep modes listen to asynchronous sources only.
  always_comb begin
    unique case (mode_r)
      SPG_SM_IDLE: begin
        wake_any = (|w) | irq_enabled_pending;
      end
      SPG_SM_ADCNR: begin
        wake_any = w.wdt_irq | w.ext_level_irq | w.pin_change_irq |
                   w.adc_done_irq | w.mem_ready_irq | w.start_frame_irq |
                   w.twi_addr_match_irq;
      end
      SPG_SM_PWRDOWN, SPG_SM_STANDBY: begin
        wake_any = w.wdt_irq | w.ext_level_irq | w.pin_change_irq |
                   w.start_frame_irq | w.twi_addr_match_irq;
      end
    endcase
  end

  always_comb begin
    state_nxt   = state_r;
    mode_nxt    = mode_r;
    cnt_nxt     = cnt_r;
    restart_nxt = 1'b0;
    unique case (state_r)
      ST_RUN: begin
        if (sleep_instr && sleep_arm_bit) begin
          state_nxt = ST_SLEEP;
          mode_nxt  = sleep_mode_select;
        end
      end
      ST_SLEEP: begin
        // A reset request wins over a wake source in the same cycle.
        if (rst_s) begin
          state_nxt   = ST_RUN;
          restart_nxt = 1'b1;
        end else if (wake_any) begin
          state_nxt = ST_START;
          // Standby keeps the oscillator, so only a short resync is needed.
          if (mode_r == SPG_SM_PWRDOWN)
            cnt_nxt = 16'(OSC_START_CYC);
          else if (mode_r == SPG_SM_STANDBY)
            cnt_nxt = 16'(SPG_STANDBY_WAKE_CYC - SPG_WAKE_HOLD_CYC - 1);
          else
            cnt_nxt = 16'h0000;
        end
      end
      ST_START: begin
        if (cnt_r == 16'h0000) begin
          state_nxt = ST_HOLD;
          cnt_nxt   = 16'(SPG_WAKE_HOLD_CYC - 1);
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      ST_HOLD: begin
        if (cnt_r == 16'h0000)
          state_nxt = ST_RUN;
        else
          cnt_nxt = cnt_r - 16'h0001;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r   <= ST_RUN;
      mode_r    <= SPG_SM_IDLE;
      cnt_r     <= 16'h0000;
      restart_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      mode_r    <= mode_nxt;
      cnt_r     <= cnt_nxt;
      restart_r <= restart_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Domain gating and analog controls
  // ----------------------------------------------------------------------
  spg_gate_t  gate_nxt;
  logic       sleeping_nxt;
  logic       deep_nxt;
  logic       hold_nxt;
  logic       auto_nxt;
  logic       comp_nxt;
  logic       adc_prev_r;
  logic       ext_r, ext_nxt;
  logic       bod_nxt;

  // Register file and SRAM are never gated or cleared here.
  always_comb begin
    sleeping_nxt = (state_nxt == ST_SLEEP);
    deep_nxt     = sleeping_nxt && mode_nxt[1];
    gate_nxt     = '{osc_en: 1'b1, clk_cpu_en: 1'b1, clk_flash_en: 1'b1,
                     clk_io_en: 1'b1, clk_adc_en: 1'b1};
    if (sleeping_nxt) begin
      gate_nxt.clk_cpu_en   = 1'b0;
      gate_nxt.clk_flash_en = 1'b0;
      unique case (mode_nxt)
        SPG_SM_IDLE: begin
        end
        SPG_SM_ADCNR: begin
          gate_nxt.clk_io_en = 1'b0;
        end
        SPG_SM_PWRDOWN: begin
          gate_nxt.clk_io_en  = 1'b0;
          gate_nxt.clk_adc_en = 1'b0;
          gate_nxt.osc_en     = 1'b0;
        end
        SPG_SM_STANDBY: begin
          gate_nxt.clk_io_en  = 1'b0;
          gate_nxt.clk_adc_en = 1'b0;
        end
      endcase
    end
    hold_nxt = (state_nxt != ST_RUN);
    auto_nxt = (state_r == ST_RUN) && (state_nxt == ST_SLEEP) && adc_enable &&
               !sleep_mode_select[1];
    comp_nxt = comp_enable && (!deep_nxt || comp_uses_ref);
    // Extended flag set on enable rise, dropped once a conversion is started.
    ext_nxt  = (adc_enable && !adc_prev_r) ? 1'b1 :
               (auto_nxt ? 1'b0 : ext_r);
    bod_nxt  = brownout_sleep_fuse;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gate              <= '{default: 1'b1};
      cpu_hold          <= 1'b0;
      cpu_restart       <= 1'b0;
      asleep            <= 1'b0;
      adc_auto_start    <= 1'b0;
      adc_prev_r        <= 1'b0;
      ext_r             <= 1'b0;
      adc_extended_conv <= 1'b0;
      comp_active       <= 1'b0;
      brownout_active   <= 1'b0;
      brownout_sampled  <= 1'b0;
      vref_enable       <= 1'b0;
    end else begin
      gate              <= gate_nxt;
      cpu_hold          <= hold_nxt;
      cpu_restart       <= restart_r;
      asleep            <= sleeping_nxt;
      adc_auto_start    <= auto_nxt;
      adc_prev_r        <= adc_enable;
      ext_r             <= ext_nxt;
      adc_extended_conv <= ext_nxt;
      comp_active       <= comp_nxt;
      brownout_active   <= bod_nxt;
      brownout_sampled  <= bod_nxt && brownout_sampled_sel;
      vref_enable       <= bod_nxt || (comp_nxt && comp_uses_ref) ||
                           adc_enable;
    end
  end

  // ----------------------------------------------------------------------
  // Per-peripheral gates
  // ----------------------------------------------------------------------
  logic io_dom_on;
  logic adc_dom_on;
  assign io_dom_on  = gate_nxt.clk_io_en;
  assign adc_dom_on = gate_nxt.clk_adc_en;

  genvar gi;
  generate
    for (gi = 0; gi < SPG_NUM_PERIPH; gi++) begin : g_pg
      spg_periph_gate u_gate (
        .clock     (clock),
        .reset     (reset),
        .pr_bit    (power_reduction_reg[gi]),
        .domain_on ((gi == SPG_PR_ADC) ? adc_dom_on : io_dom_on),
        .clk_en    (periph_clk_en[gi]),
        .access_en (periph_access_en[gi])
      );
    end
  endgenerate

endmodule : spg_sleep_ctrl

// ### spg_sleep_ctrl_sva.sv
// Purpose: Port assertions for the sleep controller.
// Assumes: One clock domain with an asynchronous active-high reset.
// Notes:   Bound to every instance of the controller.
`timescale 1ns/1ps
module spg_sleep_ctrl_sva
  import spg_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       sleep_instr,
  input wire logic       sleep_arm_bit,
  input wire logic [1:0] sleep_mode_select,
  input wire logic [7:0] power_reduction_reg,
  input wire logic       adc_enable,
  input wire spg_gate_t  gate,
  input wire logic [7:0] periph_clk_en,
  input wire logic [7:0] periph_access_en,
  input wire logic       cpu_hold,
  input wire logic       cpu_restart,
  input wire logic       asleep,
  input wire logic       adc_auto_start
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  logic take;
  logic arm_take;
  assign take     = sleep_instr && !cpu_hold;
  assign arm_take = take && sleep_arm_bit;

  a_noarm_noop: assert property (take && !sleep_arm_bit |=> !asleep && gate == 5'h1f)
    else $error("Sleep entered with the arm bit clear.");
  a_arm_enters: assert property (arm_take |=> asleep && cpu_hold)
    else $error("Armed sleep request not entered.");
  a_idle_gates: assert property (
    arm_take && sleep_mode_select == SPG_SM_IDLE |=> gate == 5'h13)
    else $error("Idle clock gating wrong.");
  a_adcnr_gates: assert property (
    arm_take && sleep_mode_select == SPG_SM_ADCNR |=> gate == 5'h11)
    else $error("ADC noise clock gating wrong.");
  a_pdown_gates: assert property (
    arm_take && sleep_mode_select == SPG_SM_PWRDOWN |=> gate == 5'h00 && periph_clk_en == 8'h00)
    else $error("Power-down clock gating wrong.");
  a_stby_gates: assert property (
    arm_take && sleep_mode_select == SPG_SM_STANDBY |=> gate == 5'h10)
    else $error("Standby clock gating wrong.");
  a_wake_hold: assert property ($fell(asleep) && cpu_hold |-> cpu_hold [*4])
    else $error("CPU hold after wake too short.");
  a_reset_restart: assert property ($fell(asleep) && !cpu_hold |=> cpu_restart)
    else $error("Reset wake gave no restart pulse.");
  a_pr_access: assert property (
    1'b1 |=> periph_access_en == ~$past(power_reduction_reg))
    else $error("Peripheral access enable does not follow reduction bits.");
  a_auto_start: assert property (
    arm_take && !sleep_mode_select[1] && adc_enable |-> ##[1:2] adc_auto_start)
    else $error("No ADC auto start on entry.");
endmodule : spg_sleep_ctrl_sva

bind spg_sleep_ctrl spg_sleep_ctrl_sva u_sva (
  .clock, .reset, .sleep_instr, .sleep_arm_bit, .sleep_mode_select, .power_reduction_reg,
  .adc_enable, .gate, .periph_clk_en, .periph_access_en, .cpu_hold, .cpu_restart,
  .asleep, .adc_auto_start
);

// ### spg_sleep_ctrl_tb_top.sv
// Purpose: Self-checking bench for the sleep controller.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes:   Outputs are sampled at falling edges.
`timescale 1ns/1ps
module spg_sleep_ctrl_tb_top;
  import spg_pkg::*;
  logic       clock = 1'b0, reset = 1'b1, go = 1'b0, arm = 1'b0, irq = 1'b0;
  logic       reset_req = 1'b0, adc_enable = 1'b0, comp_enable = 1'b1;
  logic       comp_uses_ref = 1'b0, brownout_sleep_fuse = 1'b1, brownout_sampled_sel = 1'b1;
  logic [1:0] mode = 2'h0, sleep_mode_select;
  logic [7:0] power_reduction_reg = 8'h00, periph_clk_en, periph_access_en;
  spg_wake_t  wake_src = '0;
  spg_gate_t  gate;
  logic       sleep_instr, sleep_arm_bit, irq_enabled_pending, cpu_hold, cpu_restart, asleep;
  logic       adc_auto_start, adc_extended_conv, comp_active, brownout_active;
  logic       brownout_sampled, vref_enable;
  int         miscompares = 0, total_checks = 0, cycles = 0;
  localparam int OSC_CYC = 2;

  spg_cpu_model cpu (.clock, .reset, .go, .arm, .mode, .irq, .cpu_hold, .sleep_instr,
    .sleep_arm_bit, .sleep_mode_select, .irq_enabled_pending);
  spg_sleep_ctrl #(.OSC_START_CYC(OSC_CYC)) dut (.clock, .reset, .sleep_instr, .sleep_arm_bit,
    .sleep_mode_select, .irq_enabled_pending, .wake_src, .reset_req, .power_reduction_reg,
    .adc_enable, .comp_enable, .comp_uses_ref, .brownout_sleep_fuse, .brownout_sampled_sel,
    .gate, .periph_clk_en, .periph_access_en, .cpu_hold, .cpu_restart, .asleep,
    .adc_auto_start, .adc_extended_conv, .comp_active, .brownout_active, .brownout_sampled,
    .vref_enable);

  initial forever #12.5 clock = ~clock;

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic do_sleep(input logic a, input logic [1:0] m);
    repeat (3) @(posedge clock);
    go   <= 1'b1;
    arm  <= a;
    mode <= m;
    @(posedge clock);
    go <= 1'b0;
    repeat (2) @(negedge clock);
    check({7'h0, adc_auto_start}, {7'h0, a && !m[1] && adc_enable});
    @(negedge clock);
  endtask : do_sleep

  task automatic wait_awake(output int n);
    n = 0;
    while (cpu_hold === 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
  endtask : wait_awake

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // Cycles from a pin wake to cpu_hold seen low: two sync stages, a register, start-up,
  // the four-cycle hold and the half-cycle sample offset.
  task automatic mode_wake(input logic [1:0] m, input logic [4:0] g, input logic [7:0] mask,
                           input int wake_n);
    int n;
    for (int b = 0; b < 8; b++) begin
      do_sleep(1'b1, m);
      check({3'h0, gate}, {3'h0, g});
      check({7'h0, comp_active}, {7'h0, !m[1]});
      check({5'h0, brownout_active, brownout_sampled, vref_enable}, 8'h07);
      @(posedge clock);
      wake_src <= spg_wake_t'(8'h01 << b);
      wait_awake(n);
      check({7'h0, cpu_hold}, {7'h0, !mask[b]});
      if (mask[b]) check(8'(n), 8'(wake_n));
      if (m == SPG_SM_STANDBY && mask[b])
        check({7'h0, n <= SPG_STANDBY_WAKE_CYC + 4}, 8'h01);
      @(posedge clock);
      wake_src <= 8'h80;
      wait_awake(n);
      @(posedge clock);
      wake_src <= '0;
      @(negedge clock);
      check({3'h0, gate}, 8'h1f);
    end
  endtask : mode_wake

  task automatic idle_irq_pr;
    int n;
    @(posedge clock);
    adc_enable <= 1'b0;
    @(posedge clock);
    power_reduction_reg <= 8'h81;
    repeat (2) @(negedge clock);
    check(periph_clk_en, 8'h7e);
    check(periph_access_en, 8'h7e);
    do_sleep(1'b1, SPG_SM_IDLE);
    check(periph_clk_en, 8'h7e);
    @(posedge clock);
    irq <= 1'b1;
    @(posedge clock);
    irq <= 1'b0;
    wait_awake(n);
    check({6'h0, cpu_hold, asleep}, 8'h00);
    @(posedge clock);
    power_reduction_reg <= 8'h00;
    repeat (2) @(negedge clock);
    check(periph_clk_en, 8'hff);
    check(periph_access_en, 8'hff);
    @(posedge clock);
    adc_enable <= 1'b1;
    repeat (2) @(negedge clock);
    check({7'h0, adc_extended_conv}, 8'h01);
  endtask : idle_irq_pr

  task automatic reset_wake;
    int n = 0;
    @(posedge clock);
    comp_uses_ref       <= 1'b1;
    brownout_sleep_fuse <= 1'b0;
    adc_enable          <= 1'b0;
    do_sleep(1'b1, SPG_SM_PWRDOWN);
    check({4'h0, comp_active, brownout_active, brownout_sampled, vref_enable}, 8'h09);
    @(posedge clock);
    reset_req <= 1'b1;
    while (cpu_restart !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    check({6'h0, cpu_restart, asleep}, 8'h02);
    @(posedge clock);
    reset_req   <= 1'b0;
    comp_enable <= 1'b0;
    repeat (2) @(negedge clock);
    check({7'h0, vref_enable}, 8'h00);
  endtask : reset_wake

  task automatic no_arm;
    do_sleep(1'b0, SPG_SM_PWRDOWN);
    check({2'h0, asleep, gate}, 8'h1f);
  endtask : no_arm

  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    adc_enable <= 1'b1;
    repeat (2) @(negedge clock);
    check({7'h0, adc_extended_conv}, 8'h01);
    no_arm();
    mode_wake(SPG_SM_IDLE, 5'h13, 8'hff, SPG_WAKE_HOLD_CYC + 5);
    check({7'h0, adc_extended_conv}, 8'h00);
    mode_wake(SPG_SM_ADCNR, 5'h11, 8'hfe, SPG_WAKE_HOLD_CYC + 5);
    mode_wake(SPG_SM_PWRDOWN, 5'h00, 8'he6, OSC_CYC + SPG_WAKE_HOLD_CYC + 5);
    mode_wake(SPG_SM_STANDBY, 5'h10, 8'he6, SPG_STANDBY_WAKE_CYC + 4);
    idle_irq_pr();
    reset_wake();
    report_and_stop();
  end
endmodule : spg_sleep_ctrl_tb_top
